/* shared/dskrc_pkg.sv */
package dskrc_pkg;
	// Instruction codes on instr_code
	localparam logic [2:0] IC_LOAD_CMD = 3'h1;
	localparam logic [2:0] IC_LOAD_DA = 3'h2;
	localparam logic [2:0] IC_LOAD_PTR = 3'h3;
	localparam logic [2:0] IC_RD_STATUS = 3'h4;
	localparam logic [2:0] IC_RD_DA = 3'h5;
	localparam logic [2:0] IC_RD_PTR = 3'h6;
	// Flag functions on instr_flag
	localparam logic [1:0] FL_NONE = 2'h0;
	localparam logic [1:0] FL_S = 2'h1;
	localparam logic [1:0] FL_C = 2'h2;
	localparam logic [1:0] FL_P = 2'h3;
	// Command field codes
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_SEEK = 2'h2;
	localparam logic [1:0] CMD_RECAL = 2'h3;
	// Word bit 0 of the host numbering is vector bit 15
	localparam int CT_CLR_RW = 15;
	localparam int CT_CLR_SEEK_LSB = 11;
	localparam int CT_CMD_LSB = 8;
	localparam int CT_TRK_LSB = 0;
	localparam int DA_DRV_LSB = 14;
	localparam int DA_FMT = 13;
	localparam int DA_HEAD_LSB = 10;
	localparam int DA_CARRY = 7;
	localparam int DA_SEC_LSB = 4;
	localparam int DA_CNT_LSB = 0;
	localparam int ST_RW_DONE = 15;
	localparam int ST_SEEK_LSB = 11;
	localparam int ST_DISKETTE = 10;
	localparam int ST_VALID = 9;
	localparam int ST_UNSAFE = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEK_ERR = 5;
	localparam int ST_EOT = 4;
	localparam int ST_ADDR_ERR = 3;
	localparam int ST_CK_ERR = 2;
	localparam int ST_LATE = 1;
	localparam int ST_ERROR = 0;
	// Header word layout
	localparam int HDR_TRK_LSB = 3;
	localparam int HDR_SEC_LSB = 0;
	localparam int SECTOR_WORDS = 256;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] DA_RESET = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	typedef enum logic [4:0] {
		DSKRC_IDLE = 5'h01,
		DSKRC_WAIT = 5'h02,
		DSKRC_HDR = 5'h04,
		DSKRC_DATA = 5'h08,
		DSKRC_CHK = 5'h10
	} dskrc_state_e;

	// Drive 0 sits in the highest bit of a four-drive field
	function automatic logic [3:0] dskrc_rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction : dskrc_rev4
endpackage : dskrc_pkg

/* shared/dskrc_bit_if.sv */
`timescale 1ns/1ps
interface dskrc_bit_if;
	logic bit_stb;
	logic bit_in;
	logic load;
	logic [15:0] load_word;
	logic [15:0] word;
	logic word_done;
	logic bit_out;
	logic crc_clr;
	logic crc_en;
	logic crc_bit;
	logic [15:0] crc;
	modport shifter (input bit_stb, bit_in, load, load_word,
		output word, word_done, bit_out);
	modport crcgen (input bit_stb, crc_clr, crc_en, crc_bit, output crc);
	modport ctl (output bit_stb, bit_in, load, load_word, crc_clr, crc_en,
		crc_bit, input word, word_done, bit_out, crc);
endinterface : dskrc_bit_if

/* hw/dskrc_shift.sv */
`timescale 1ns/1ps
module dskrc_shift
(
	input wire logic clk_sys,
	input wire logic resetn,
	dskrc_bit_if.shifter bi
);
	logic [15:0] word_q;
	logic [3:0] cnt_q;
	logic done_q;

	assign bi.word = word_q;
	assign bi.word_done = done_q;
	assign bi.bit_out = word_q[15];

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			word_q <= 16'h0000;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
		end
		else if (bi.load)
		begin
			word_q <= bi.load_word;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= bi.bit_stb && (cnt_q == 4'hf);
			if (bi.bit_stb)
			begin
				word_q <= {word_q[14:0], bi.bit_in};
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule : dskrc_shift

/* hw/dskrc_crc.sv */
`timescale 1ns/1ps
module dskrc_crc
	import dskrc_pkg::*;
#(
	parameter logic [15:0] POLY = CRC_POLY
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	dskrc_bit_if.crcgen bi
);
	logic [15:0] crc_q;
	logic fb;

	assign fb = crc_q[15] ^ bi.crc_bit;
	assign bi.crc = crc_q;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			crc_q <= CRC_INIT;
		else if (bi.crc_clr)
			crc_q <= CRC_INIT;
		else if (bi.crc_en && bi.bit_stb)
			crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
	end
endmodule : dskrc_crc

/* hw/dskrc_top.sv */
`timescale 1ns/1ps
// How it works
// - Disc address readback packs drive, format, sector, count
// - Sector field wraps 7 to 0, sets bit 8
// - Head bits stored and returned, changed only by the end of track bump
// - End of track without counter overflow or checkword error bumps head bits by one
// - Format bit stored and read back as written
// - Pointer readback in bits 1-15, bit 0 zero
// - Write ends with pointer two past last
// - Pulse-started seek keeps busy, clears done
// - Seeking drive shows not ready; completion sets flag
// - Start flag read sets busy, clears done
// - Blocks of 256 words, one to eight sectors
// - Header track and sector must match
// - Checkword computed over incoming data bits
// - Words assembled, sent, pointer plus one each
// - After word 256 advance sector, read checkword
// - Recorded checkword compared with computed one
// - Continue until counter overflow, track end, header mismatch or checkword error
// - Completion clears busy, sets done, interrupts if started with the S flag or while busy
// - Command field: read, write, seek, recalibrate
// - Every seek or recalibrate end interrupts
// - Header mismatch sets address error bit
// - Checkword mismatch sets checkword error bit
module dskrc_top
	import dskrc_pkg::*;
#(
	parameter int WORDS = SECTOR_WORDS,
	parameter logic [15:0] POLY = CRC_POLY
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic io_reset,
	input wire logic instr_valid,
	input wire logic [2:0] instr_code,
	input wire logic [1:0] instr_flag,
	input wire logic [15:0] instr_wdata,
	output logic [15:0] instr_rdata,
	output logic instr_rvalid,
	output logic dch_req,
	output logic dch_to_mem,
	output logic [14:0] dch_addr,
	output logic [15:0] dch_wdata,
	input wire logic [15:0] dch_rdata,
	input wire logic dch_ack,
	output logic irq,
	output logic [1:0] drv_unit,
	output logic [6:0] drv_track,
	output logic drv_seek_go,
	output logic drv_recal,
	output logic drv_wr_bit,
	output logic drv_wr_gate,
	input wire logic drv_bit,
	input wire logic drv_bit_clk,
	input wire logic drv_sector_mark,
	input wire logic [2:0] drv_sector_num,
	input wire logic [3:0] drv_ready,
	input wire logic drv_unsafe,
	input wire logic drv_seek_err
);
	localparam int WW = $clog2(WORDS);

	dskrc_bit_if bi ();
	dskrc_shift u_shift (.clk_sys(clk_sys), .resetn(resetn), .bi(bi));
	dskrc_crc #(.POLY(POLY)) u_crc (.clk_sys(clk_sys), .resetn(resetn),
		.bi(bi));

	// Pins: two flops, a third only for edge detection
	logic [11:0] s1_q, s2_q, s3_q;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_q <= 12'h000;
			s2_q <= 12'h000;
			s3_q <= 12'h000;
		end
		else
		begin
			s1_q <= {drv_bit, drv_bit_clk, drv_sector_mark, drv_sector_num,
				drv_ready, drv_unsafe, drv_seek_err};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	wire bit_s = s2_q[11];
	wire bit_rise = s2_q[10] && !s3_q[10];
	wire mark_rise = s2_q[9] && !s3_q[9];
	wire [2:0] snum_s = s2_q[8:6];
	wire [3:0] rdy_s = s2_q[5:2];
	wire [3:0] rdy_rise = s2_q[5:2] & ~s3_q[5:2];
	wire unsafe_s = s2_q[1];
	wire seekerr_s = s2_q[0];

	dskrc_state_e st_q, st_d;
	logic [15:0] cmd_q, da_q, dbuf_q, rdata_q;
	logic [14:0] ptr_q;
	logic [WW-1:0] words_q;
	logic [3:0] seek_done_q, seeking_q;
	logic busy_q, done_q, arm_q, wr_q, dfull_q, rvalid_q, go_q;
	logic unsafe_q, seekerr_q, eot_q, addr_q, ck_q, late_q;

	wire any_rst = io_reset;
	wire ld_cmd = instr_valid && instr_code == IC_LOAD_CMD;
	wire ld_da = instr_valid && instr_code == IC_LOAD_DA;
	wire ld_ptr = instr_valid && instr_code == IC_LOAD_PTR;
	wire rd_any = instr_valid && instr_code[2] && instr_code != 3'h7;
	wire fl_s = instr_valid && instr_flag == FL_S;
	wire fl_c = instr_valid && instr_flag == FL_C;
	wire fl_p = instr_valid && instr_flag == FL_P;
	wire [15:0] cmd_now = ld_cmd ? instr_wdata : cmd_q;
	wire [1:0] cmd_sel = cmd_now[CT_CMD_LSB +: 2];
	wire idle = st_q == DSKRC_IDLE;
	wire go_xfer = (fl_s || fl_p) && !cmd_sel[1] && idle;
	wire go_seek = (fl_s || fl_p) && cmd_sel[1];
	wire [1:0] unit = da_q[DA_DRV_LSB +: 2];
	wire [2:0] sec = da_q[DA_SEC_LSB +: 3];
	wire [3:0] cnt_nx = da_q[DA_CNT_LSB +: 4] + 4'h1;

	wire hdr_done = st_q == DSKRC_HDR && bi.word_done;
	wire hdr_ok = bi.word[HDR_TRK_LSB +: 7] == cmd_q[CT_TRK_LSB +: 7]
		&& bi.word[HDR_SEC_LSB +: 3] == sec;
	wire data_word = st_q == DSKRC_DATA && bi.word_done;
	wire last_word = data_word && words_q == WW'(WORDS - 1);
	wire chk_done = st_q == DSKRC_CHK && bi.word_done;
	wire ck_bad = chk_done && !wr_q && bi.word != bi.crc;
	wire cnt_ovf = da_q[DA_CNT_LSB +: 4] == 4'h0;
	wire eot_ev = chk_done && !ck_bad && !cnt_ovf && da_q[DA_CARRY];
	wire finish = (hdr_done && !hdr_ok)
		|| (chk_done && (ck_bad || cnt_ovf || da_q[DA_CARRY]));
	wire late_ev = data_word && (wr_q ? (!last_word && !dfull_q) : dfull_q);
	wire seek_end = |(seeking_q & rdy_rise);
	wire [3:0] sk_go = go_seek ? 4'h1 << unit : 4'h0;
	wire [3:0] sk_end = seeking_q & rdy_rise;
	wire [3:0] sk_clr = {4{fl_c}}
		| (ld_cmd ? dskrc_rev4(instr_wdata[CT_CLR_SEEK_LSB +: 4]) : 4'h0);

	// Shifter reloads: cleared on header, fed from buffer or checkword
	wire wr_first = wr_q && hdr_done && hdr_ok;
	wire wr_next = wr_q && data_word && !last_word;
	wire wr_crc = wr_q && last_word;
	wire enter_hdr = st_q == DSKRC_WAIT && mark_rise && snum_s == sec;
	assign bi.bit_stb = bit_rise;
	assign bi.bit_in = bit_s;
	assign bi.load = enter_hdr || wr_first || wr_next || wr_crc;
	assign bi.load_word = wr_crc ? bi.crc : (enter_hdr ? 16'h0000 : dbuf_q);
	assign bi.crc_clr = hdr_done;
	assign bi.crc_en = st_q == DSKRC_DATA;
	assign bi.crc_bit = wr_q ? bi.bit_out : bit_s;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			DSKRC_IDLE: if (go_xfer) st_d = DSKRC_WAIT;
			DSKRC_WAIT: if (enter_hdr) st_d = DSKRC_HDR;
			DSKRC_HDR: if (hdr_done) st_d = hdr_ok ? DSKRC_DATA : DSKRC_IDLE;
			DSKRC_DATA: if (last_word) st_d = DSKRC_CHK;
			DSKRC_CHK: if (chk_done) st_d = finish ? DSKRC_IDLE : DSKRC_WAIT;
			default: st_d = DSKRC_IDLE;
		endcase
		if (fl_c)
			st_d = DSKRC_IDLE;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= DSKRC_IDLE;
			words_q <= '0;
		end
		else if (any_rst)
		begin
			st_q <= DSKRC_IDLE;
			words_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			if (hdr_done)
				words_q <= '0;
			else if (data_word)
				words_q <= words_q + WW'(1);
		end
	end

	// Registers loaded by the host; disc address and pointer advanced by the transfer
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_q <= CMD_RESET;
			da_q <= DA_RESET;
			ptr_q <= 15'h0000;
		end
		else if (any_rst)
		begin
			cmd_q <= CMD_RESET;
			da_q <= DA_RESET;
			ptr_q <= 15'h0000;
		end
		else
		begin
			if (ld_cmd)
				cmd_q <= instr_wdata;
			if (ld_da)
				da_q <= instr_wdata;
			else if (last_word)
			begin
				da_q[DA_SEC_LSB +: 3] <= sec + 3'h1;
				da_q[DA_CARRY] <= sec == 3'h7;
				da_q[DA_CNT_LSB +: 4] <= cnt_nx;
			end
			else if (eot_ev)
				da_q[DA_HEAD_LSB +: 3] <= da_q[DA_HEAD_LSB +: 3] + 3'h1;
			if (ld_ptr)
				ptr_q <= instr_wdata[14:0];
			else if (dch_req && dch_ack)
				ptr_q <= ptr_q + 15'h0001;
		end
	end

	// One-word buffer between shifter and data channel
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			dbuf_q <= 16'h0000;
			dfull_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else if (any_rst || fl_c)
			dfull_q <= 1'b0;
		else
		begin
			if (go_xfer)
			begin
				wr_q <= cmd_sel == CMD_WRITE;
				dfull_q <= 1'b0;
			end
			else if (!wr_q && data_word)
			begin
				dbuf_q <= bi.word;
				dfull_q <= 1'b1;
			end
			else if (wr_first || wr_next)
				dfull_q <= 1'b0;
			else if (dch_req && dch_ack)
			begin
				// Write keeps one word ahead, hence the +2 pointer
				if (wr_q)
					dbuf_q <= dch_rdata;
				dfull_q <= wr_q;
			end
		end
	end

	// Busy, done and error flags; hardware sets win over clears, except the C flag blocks completion setting done
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			{busy_q, done_q, arm_q} <= 3'h0;
			{unsafe_q, seekerr_q, eot_q, addr_q, ck_q, late_q} <= 6'h00;
		end
		else if (any_rst)
		begin
			{busy_q, done_q, arm_q} <= 3'h0;
			{unsafe_q, seekerr_q, eot_q, addr_q, ck_q, late_q} <= 6'h00;
		end
		else
		begin
			if (ld_cmd && instr_wdata[CT_CLR_RW])
				{done_q, addr_q, ck_q, eot_q, unsafe_q} <= 5'h00;
			if (fl_s)
			begin
				busy_q <= 1'b1;
				done_q <= 1'b0;
				{addr_q, eot_q, ck_q, late_q, unsafe_q} <= 5'h00;
			end
			if (fl_p)
			begin
				done_q <= 1'b0;
				{unsafe_q, seekerr_q, eot_q, addr_q, ck_q, late_q} <= 6'h00;
			end
			if (fl_c)
			begin
				{busy_q, done_q} <= 2'h0;
				{unsafe_q, seekerr_q, eot_q, addr_q, ck_q, late_q} <= 6'h00;
			end
			if (go_xfer)
				arm_q <= fl_s || busy_q;
			if (finish && !fl_c)
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
			if (hdr_done && !hdr_ok)
				addr_q <= 1'b1;
			if (ck_bad)
				ck_q <= 1'b1;
			if (eot_ev)
				eot_q <= 1'b1;
			if (late_ev)
				late_q <= 1'b1;
			if (unsafe_s)
				unsafe_q <= 1'b1;
			if (seek_end && seekerr_s)
				seekerr_q <= 1'b1;
		end
	end

	// Seeks run beside transfers; the drive reports by raising ready
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			seek_done_q <= 4'h0;
			seeking_q <= 4'h0;
			go_q <= 1'b0;
			drv_recal <= 1'b0;
			drv_track <= 7'h00;
		end
		else if (any_rst)
		begin
			seek_done_q <= 4'h0;
			go_q <= 1'b0;
		end
		else
		begin
			go_q <= go_seek;
			// Clears and a new start first, completion last: the set wins
			seek_done_q <= (seek_done_q & ~sk_clr & ~sk_go) | sk_end;
			seeking_q <= (seeking_q & ~rdy_rise) | sk_go;
			if (go_seek)
			begin
				drv_track <= cmd_now[CT_TRK_LSB +: 7];
				drv_recal <= cmd_sel == CMD_RECAL;
			end
		end
	end

	wire [15:0] status_w = {done_q, dskrc_rev4(seek_done_q), 1'b1, 1'b1,
		1'b0, unsafe_q, rdy_s[unit] && !seeking_q[unit], seekerr_q, eot_q,
		addr_q, ck_q, late_q,
		unsafe_q || seekerr_q || eot_q || addr_q || ck_q || late_q};

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= rd_any;
			case (instr_code)
				IC_RD_STATUS: rdata_q <= status_w;
				IC_RD_DA: rdata_q <= da_q;
				IC_RD_PTR: rdata_q <= {1'b0, ptr_q};
				default: rdata_q <= 16'h0000;
			endcase
		end
	end

	assign instr_rdata = rdata_q;
	assign instr_rvalid = rvalid_q;
	assign dch_to_mem = !wr_q;
	assign dch_addr = ptr_q;
	assign dch_wdata = dbuf_q;
	assign dch_req = wr_q ? (!dfull_q && !idle) : dfull_q;
	assign irq = (done_q && arm_q) || |seek_done_q;
	assign drv_unit = unit;
	assign drv_seek_go = go_q;
	assign drv_wr_bit = bi.bit_out;
	assign drv_wr_gate = wr_q && (st_q == DSKRC_DATA || st_q == DSKRC_CHK);

	AST_RD_PTR: assert property (@(posedge clk_sys) disable iff (!resetn)
		instr_valid && instr_code == IC_RD_PTR |=>
		instr_rdata == {1'b0, $past(ptr_q)}) else $error("pointer readback");
	AST_S_START: assert property (@(posedge clk_sys) disable iff (!resetn)
		go_xfer && fl_s && !any_rst |=> busy_q && !done_q)
		else $error("start flag");
	AST_P_BUSY: assert property (@(posedge clk_sys) disable iff (!resetn)
		go_seek && fl_p && idle && !any_rst |=>
		busy_q == $past(busy_q) && !done_q) else $error("pulse seek");
	AST_FINISH: assert property (@(posedge clk_sys) disable iff (!resetn)
		finish && !fl_c && !any_rst |=> !busy_q && done_q && idle)
		else $error("completion flags");
	AST_NOT_READY: assert property (@(posedge clk_sys) disable iff (!resetn)
		instr_valid && instr_code == IC_RD_STATUS && seeking_q[unit] |=>
		!instr_rdata[ST_READY]) else $error("ready while seek");
	AST_PTR_INC: assert property (@(posedge clk_sys) disable iff (!resetn)
		dch_req && dch_ack && !ld_ptr && !any_rst |=>
		ptr_q == $past(ptr_q) + 15'h0001) else $error("pointer step");
	AST_SEC_ADV: assert property (@(posedge clk_sys) disable iff (!resetn)
		last_word && !ld_da && !any_rst |=>
		da_q[DA_SEC_LSB +: 3] == $past(sec) + 3'h1 && st_q != DSKRC_DATA)
		else $error("sector advance");
	AST_CK_ERR: assert property (@(posedge clk_sys) disable iff (!resetn)
		ck_bad && !fl_c && !any_rst |=> ck_q && done_q)
		else $error("checkword error");
	AST_ADDR_ERR: assert property (@(posedge clk_sys) disable iff (!resetn)
		hdr_done && !hdr_ok && !any_rst |=> addr_q && idle)
		else $error("address error");
	AST_EOT_HEAD: assert property (@(posedge clk_sys) disable iff (!resetn)
		eot_ev && !ld_da && !any_rst |=> da_q[DA_HEAD_LSB +: 3] ==
		$past(da_q[DA_HEAD_LSB +: 3]) + 3'h1) else $error("head bump");
	AST_SEEK_IRQ: assert property (@(posedge clk_sys) disable iff (!resetn)
		seek_end && !any_rst |=> irq) else $error("seek interrupt");
endmodule : dskrc_top

/* testbench/dskrc_drive_model.sv */
`timescale 1ns/1ps
module dskrc_drive_model
	import dskrc_pkg::*;
#(
	parameter int WORDS = 4,
	parameter int HALF = 4,
	parameter int SEEK_CYCLES = 2000
)
(
	input wire logic clk_sys,
	input wire logic drv_seek_go,
	input wire logic drv_recal,
	input wire logic [6:0] drv_track,
	input wire logic bad_crc,
	output logic drv_bit,
	output logic drv_bit_clk,
	output logic drv_sector_mark,
	output logic [2:0] drv_sector_num,
	output logic [3:0] drv_ready
);
	logic [6:0] pos_trk;
	logic [15:0] crc;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	// Checkword runs MSB first over data bits only
	task automatic send(input logic [15:0] w, input logic ck);
		for (int i = 15; i >= 0; i--)
		begin
			drv_bit = w[i];
			if (ck)
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[i]) ? CRC_POLY : 16'h0);
			tick(HALF);
			drv_bit_clk = 1;
			tick(HALF);
			drv_bit_clk = 0;
		end
	endtask : send

	// Single drive on unit 0; the disc spins whatever the controller does
	initial
	begin
		pos_trk = 7'h00;
		crc = CRC_INIT;
		drv_bit = 0;
		drv_bit_clk = 0;
		drv_sector_mark = 0;
		drv_sector_num = 3'h0;
		drv_ready = 4'hf;
		forever
			for (int s = 0; s < 8; s++)
			begin
				drv_sector_num = 3'(s);
				drv_sector_mark = 1;
				tick(4);
				drv_sector_mark = 0;
				tick(8);
				send((16'(pos_trk) << HDR_TRK_LSB) | 16'(s), 1'b0);
				crc = CRC_INIT;
				for (int w = 0; w < WORDS; w++)
					send({5'h15, 3'(s), 8'(w)}, 1'b1);
				send(crc ^ 16'(bad_crc), 1'b0);
				// Released line must not keep showing the last bit
				drv_bit = ~drv_bit;
				tick(8);
			end
	end

	always @(posedge clk_sys)
	begin
		if (drv_seek_go === 1'b1)
		begin
			#1;
			drv_ready[0] = 0;
			pos_trk = drv_recal ? 7'h00 : drv_track;
			tick(SEEK_CYCLES);
			drv_ready[0] = 1;
		end
	end
endmodule : dskrc_drive_model

/* testbench/test_dskrc_top.sv */
`timescale 1ns/1ps
module test_dskrc_top
	import dskrc_pkg::*;
();
	localparam int WORDS = 4;
	logic clk_sys, resetn, instr_valid, instr_rvalid, dch_req, dch_ack, irq;
	logic [2:0] instr_code;
	logic [1:0] instr_flag;
	logic [15:0] instr_wdata, instr_rdata, dch_wdata, v;
	logic [14:0] dch_addr, exp_ptr;
	logic [6:0] drv_track;
	logic drv_seek_go, drv_recal, drv_bit, drv_bit_clk, drv_sector_mark;
	logic [2:0] drv_sector_num, exp_sec;
	logic [3:0] drv_ready;
	logic bad_crc;
	int miscompares, checks_done, widx;

	dskrc_top #(.WORDS(WORDS)) i_dskrc_top (.clk_sys(clk_sys),
		.resetn(resetn), .io_reset(1'b0), .instr_valid(instr_valid),
		.instr_code(instr_code), .instr_flag(instr_flag),
		.instr_wdata(instr_wdata), .instr_rdata(instr_rdata),
		.instr_rvalid(instr_rvalid), .dch_req(dch_req), .dch_to_mem(),
		.dch_addr(dch_addr), .dch_wdata(dch_wdata), .dch_rdata(16'h0000),
		.dch_ack(dch_ack), .irq(irq), .drv_unit(), .drv_track(drv_track),
		.drv_seek_go(drv_seek_go), .drv_recal(drv_recal), .drv_wr_bit(),
		.drv_wr_gate(), .drv_bit(drv_bit), .drv_bit_clk(drv_bit_clk),
		.drv_sector_mark(drv_sector_mark), .drv_sector_num(drv_sector_num),
		.drv_ready(drv_ready), .drv_unsafe(1'b0), .drv_seek_err(1'b0));

	dskrc_drive_model #(.WORDS(WORDS)) i_dskrc_drive_model (.clk_sys(clk_sys),
		.drv_seek_go(drv_seek_go), .drv_recal(drv_recal),
		.drv_track(drv_track), .bad_crc(bad_crc), .drv_bit(drv_bit),
		.drv_bit_clk(drv_bit_clk), .drv_sector_mark(drv_sector_mark),
		.drv_sector_num(drv_sector_num), .drv_ready(drv_ready));

	always #20 clk_sys = ~clk_sys;

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Two cycles per instruction so valid never toggles twice in a step
	task automatic io(input logic [2:0] c, input logic [1:0] f,
		input logic [15:0] w);
		@(posedge clk_sys);
		#1;
		instr_valid = 1;
		instr_code = c;
		instr_flag = f;
		instr_wdata = w;
		@(posedge clk_sys);
		#1;
		instr_valid = 0;
	endtask : io

	task automatic rd(input logic [2:0] c, output logic [15:0] r);
		io(c, FL_NONE, 16'h0000);
		chk({15'h0, instr_rvalid}, 16'h0001);
		r = instr_rdata;
	endtask : rd

	task automatic st(input int b, input logic e);
		logic [15:0] r;
		rd(IC_RD_STATUS, r);
		chk({15'h0, r[b]}, {15'h0, e});
	endtask : st

	task automatic wait_bit(input int b);
		logic [15:0] r;
		for (int i = 0; i < 400; i++)
		begin
			rd(IC_RD_STATUS, r);
			if (r[b] === 1'b1)
				break;
			repeat (40) @(posedge clk_sys);
		end
	endtask : wait_bit

	function automatic logic [15:0] da(input logic [1:0] d, input logic f,
		input logic [2:0] h, input logic c, input logic [2:0] s,
		input logic [3:0] n);
		return (16'(d) << DA_DRV_LSB) | (16'(f) << DA_FMT)
			| (16'(h) << DA_HEAD_LSB) | (16'(c) << DA_CARRY)
			| (16'(s) << DA_SEC_LSB) | (16'(n) << DA_CNT_LSB);
	endfunction : da

	function automatic logic [15:0] cmdw(input logic [1:0] c,
		input logic [6:0] t, input logic r);
		return (16'(r) << CT_CLR_RW) | (16'hf << CT_CLR_SEEK_LSB)
			| (16'(c) << CT_CMD_LSB) | (16'(t) << CT_TRK_LSB);
	endfunction : cmdw

	task automatic xfer(input logic [2:0] s, input logic [3:0] n,
		input logic [2:0] h, input logic [6:0] t, input logic r);
		io(IC_LOAD_DA, FL_NONE, da(2'h0, 1'b0, h, 1'b0, s, n));
		io(IC_LOAD_PTR, FL_NONE, 16'h0100);
		exp_ptr = 15'h0100;
		exp_sec = s;
		widx = 0;
		io(IC_LOAD_CMD, FL_S, cmdw(CMD_READ, t, r));
	endtask : xfer

	// Data channel answers every request on the next cycle
	always @(posedge clk_sys)
	begin
		#1;
		if (dch_ack)
			dch_ack = 0;
		else if (dch_req === 1'b1)
		begin
			chk({1'b0, dch_addr}, {1'b0, exp_ptr});
			chk(dch_wdata, {5'h15, exp_sec, 8'(widx)});
			exp_ptr++;
			widx++;
			if (widx == WORDS)
			begin
				exp_sec++;
				widx = 0;
			end
			dch_ack = 1;
		end
	end

	initial
	begin
		// Worst case is about 31000 cycles: three seeks, four revolutions
		#(40 * 60000);
		miscompares++;
		summarize();
	end

	initial
	begin
		clk_sys = 0;
		resetn = 0;
		instr_valid = 0;
		instr_code = 3'h0;
		instr_flag = FL_NONE;
		instr_wdata = 16'h0000;
		dch_ack = 0;
		bad_crc = 0;
		exp_ptr = 15'h0000;
		exp_sec = 3'h0;
		widx = 0;
		repeat (5) @(posedge clk_sys);
		#1;
		resetn = 1;

		rd(IC_RD_DA, v);
		chk(v, DA_RESET);
		io(IC_LOAD_DA, FL_NONE, da(2'h3, 1'b1, 3'h5, 1'b0, 3'h3, 4'hb));
		rd(IC_RD_DA, v);
		chk(v, da(2'h3, 1'b1, 3'h5, 1'b0, 3'h3, 4'hb));
		chk({15'h0, v[DA_FMT]}, 16'h0001);
		io(IC_LOAD_PTR, FL_NONE, 16'hffff);
		rd(IC_RD_PTR, v);
		chk(v, 16'h7fff);
		$display("test registers done");

		for (int k = 0; k < 2; k++)
		begin
			io(IC_LOAD_DA, FL_NONE, da(2'h0, 1'b0, 3'h0, 1'b0, 3'h0, 4'h0));
			st(ST_READY, 1'b1);
			st(ST_DISKETTE, 1'b1);
			io(IC_LOAD_CMD, FL_P, cmdw(k ? CMD_SEEK : CMD_RECAL, 7'h05, 1'b1));
			repeat (8) @(posedge clk_sys);
			st(ST_READY, 1'b0);
			st(ST_SEEK_LSB + 3, 1'b0);
			st(ST_RW_DONE, 1'b0);
			wait_bit(ST_SEEK_LSB + 3);
			st(ST_SEEK_LSB + 3, 1'b1);
			chk({15'h0, irq}, 16'h0001);
			st(ST_READY, 1'b1);
			st(ST_ERROR, 1'b0);
		end
		$display("test seek done");

		xfer(3'h6, 4'he, 3'h2, 7'h05, 1'b1);
		wait_bit(ST_RW_DONE);
		chk({15'h0, irq}, 16'h0001);
		st(ST_CK_ERR, 1'b0);
		st(ST_ADDR_ERR, 1'b0);
		st(ST_EOT, 1'b0);
		rd(IC_RD_DA, v);
		chk(v, da(2'h0, 1'b0, 3'h2, 1'b1, 3'h0, 4'h0));
		rd(IC_RD_PTR, v);
		chk(v, 16'h0100 + 16'(2 * WORDS));
		$display("test read done");

		// Head bits at 7 wrap to 0 on the end of track bump
		xfer(3'h7, 4'he, 3'h7, 7'h05, 1'b0);
		st(ST_RW_DONE, 1'b0);
		wait_bit(ST_RW_DONE);
		st(ST_EOT, 1'b1);
		st(ST_CK_ERR, 1'b0);
		rd(IC_RD_DA, v);
		chk(v, da(2'h0, 1'b0, 3'h0, 1'b1, 3'h0, 4'hf));
		rd(IC_RD_PTR, v);
		chk(v, 16'h0100 + 16'(WORDS));
		$display("test end of track done");

		// A bad checkword ends the run after its sector, no end of track
		bad_crc = 1;
		xfer(3'h0, 4'hf, 3'h0, 7'h05, 1'b1);
		wait_bit(ST_RW_DONE);
		st(ST_CK_ERR, 1'b1);
		st(ST_EOT, 1'b0);
		rd(IC_RD_DA, v);
		chk(v, da(2'h0, 1'b0, 3'h0, 1'b0, 3'h1, 4'h0));
		$display("test checkword done");

		bad_crc = 0;
		xfer(3'h1, 4'hf, 3'h0, 7'h09, 1'b1);
		wait_bit(ST_ADDR_ERR);
		st(ST_ADDR_ERR, 1'b1);
		rd(IC_RD_PTR, v);
		chk(v, 16'h0100);
		st(ST_RW_DONE, 1'b1);
		$display("test address error done");

		// Pulse seek with the clear bit off must still drop done
		io(IC_LOAD_CMD, FL_P, cmdw(CMD_SEEK, 7'h05, 1'b0));
		st(ST_RW_DONE, 1'b0);
		wait_bit(ST_SEEK_LSB + 3);
		chk({15'h0, irq}, 16'h0001);
		$display("test pulse seek done");
		summarize();
	end
endmodule : test_dskrc_top
